// file: hw/dma_channel_control.v
// one dma channel: registers, transfer sequencer and bus arbitration
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dma_channel_defs.vh"

// What this block does
// - irq when match count equals index, before advance
// - irq only while irq enable bit set
// - length field is item count minus one
// - fill mode: one fetch, same value everywhere
// - fill transfer never yields to other channels, unless triggered
// - yield clear, untriggered: back-to-back, lower masters locked out
// - yield set: one wait after store, unless triggered or fill
// - arbitration grants highest priority field
// - equal priority: lower channel number wins
// - normal mode stops and clears run bit
// - circular with trigger: keep running, index to zero, restart
// - source address steps by width when enabled, except in fill mode
// - destination address steps by width when enabled
// - untriggered starts at once, triggered waits request
// - width field: byte, half, word, 11 reserved
// - run bit enables; hardware clears on completion
// - index counts items, returns to zero at end
// - addresses from start, index, increment, width
// - source start from two 16-bit halves
// - destination start from two 16-bit halves
module dma_channel_control #(
    parameter NUM_CH = 8,
    parameter CH_ID  = 0
) (
    input  wire                 clk_i,
    input  wire                 rst_n_i,
    // register port
    input  wire [31:0]          reg_addr_i,
    input  wire [15:0]          reg_wdata_i,
    input  wire                 reg_we_i,
    input  wire                 reg_re_i,
    output reg  [15:0]          reg_rdata_o,
    // other channels competing for the bus
    input  wire [NUM_CH-1:0]    other_req_i,
    input  wire [3*NUM_CH-1:0]  other_prio_i,
    // selected peripheral request
    input  wire                 periph_req_i,
    // system bus master
    output reg                  bus_req_o,
    output reg                  bus_lock_o,
    output reg  [31:0]          mem_addr_o,
    output reg  [1:0]           mem_size_o,
    output reg                  mem_rd_o,
    output reg                  mem_wr_o,
    output reg  [31:0]          mem_wdata_o,
    input  wire [31:0]          mem_rdata_i,
    // status
    output reg                  busy_o,
    output reg                  irq_o
);

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_REQ   = 3'h1;
    localparam [2:0] S_READ  = 3'h2;
    localparam [2:0] S_WRITE = 3'h3;
    localparam [2:0] S_DONE  = 3'h4;
    localparam [2:0] S_GAP   = 3'h5;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // address of item idx; a cleared increment keeps the start address
    function [31:0] item_addr;
        input [31:0] start;
        input        inc;
        input [1:0]  width;
        input [15:0] idx;
        reg   [31:0] ofs;
        begin
            case (width)
                `WIDTH_HALF: ofs = {15'h0, idx, 1'b0};
                `WIDTH_WORD: ofs = {14'h0, idx, 2'b00};
                default:     ofs = {16'h0, idx};
            endcase
            item_addr = inc ? start + ofs : start;
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [15:0] match_count_q;
    reg [15:0] length_q;
    reg [15:0] ctrl_q;
    reg [15:0] index_q;
    reg [15:0] src_low_q;
    reg [15:0] src_high_q;
    reg [15:0] dst_low_q;
    reg [15:0] dst_high_q;
    reg [2:0]  state_q;
    reg [31:0] data_q;
    reg        hold_q;

    // control field views
    wire       run        = ctrl_q[`CTRL_RUN_BIT];
    wire [1:0] width      = ctrl_q[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB];
    wire       irq_en     = ctrl_q[`CTRL_IRQ_EN_BIT];
    wire       triggered  = ctrl_q[`CTRL_TRIG_BIT];
    wire       dst_inc    = ctrl_q[`CTRL_DST_INC_BIT];
    wire       src_inc    = ctrl_q[`CTRL_SRC_INC_BIT];
    wire       circular   = ctrl_q[`CTRL_CIRC_BIT];
    wire [2:0] prio       = ctrl_q[`CTRL_PRIO_MSB:`CTRL_PRIO_LSB];
    wire       yield      = ctrl_q[`CTRL_YIELD_BIT];
    wire       fill       = ctrl_q[`CTRL_FILL_BIT];

    // 32-bit start addresses from their halves
    wire [31:0] src_start = {src_high_q, src_low_q};
    wire [31:0] dst_start = {dst_high_q, dst_low_q};

    // fill mode fetches the source only for the first item
    wire [31:0] src_addr  = item_addr(src_start, src_inc & ~fill, width, index_q);
    wire [31:0] dst_addr  = item_addr(dst_start, dst_inc, width, index_q);

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    wire wr_match = reg_we_i && reg_addr_i == `OFS_IRQ_MATCH_COUNT;
    wire wr_len   = reg_we_i && reg_addr_i == `OFS_TRANSFER_LENGTH;
    wire wr_ctrl  = reg_we_i && reg_addr_i == `OFS_CHANNEL_CONTROL;
    wire wr_srcl  = reg_we_i && reg_addr_i == `OFS_SOURCE_START_LOW;
    wire wr_srch  = reg_we_i && reg_addr_i == `OFS_SOURCE_START_HIGH;
    wire wr_dstl  = reg_we_i && reg_addr_i == `OFS_DEST_START_LOW;
    wire wr_dsth  = reg_we_i && reg_addr_i == `OFS_DEST_START_HIGH;

    // software clearing run stops the channel wherever it is
    wire sw_stop  = wr_ctrl && !reg_wdata_i[`CTRL_RUN_BIT];

    // ----------------------------------------
    // arbitration against the other channels
    // ----------------------------------------
    wire [NUM_CH-1:0]   arb_req;
    wire [3*NUM_CH-1:0] arb_prio;
    wire [NUM_CH-1:0]   arb_gnt;
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_slot
            assign arb_req[g]          = (g == CH_ID) ? (state_q == S_REQ) : other_req_i[g];
            assign arb_prio[3*g +: 3]  = (g == CH_ID) ? prio : other_prio_i[3*g +: 3];
        end
    endgenerate

    channel_priority_arbiter #(
        .NUM_CH (NUM_CH)
    ) u_arb (
        .req_i  (arb_req),
        .prio_i (arb_prio),
        .gnt_o  (arb_gnt)
    );

    // a held bus needs no new grant; this is what keeps fill and blocking
    // transfers from being split by other channels
    wire won = hold_q || arb_gnt[CH_ID];

    // a channel holds the bus for the whole transfer in fill mode or when
    // it does not yield; triggered channels release between requests
    wire keep_bus = fill || (!yield && !triggered);

    // item bookkeeping at the end of a store
    wire last_item = index_q == length_q;

    // ----------------------------------------
    // register file writes and index
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            match_count_q <= `REG_RESET;
            length_q      <= `REG_RESET;
            ctrl_q        <= `REG_RESET;
            src_low_q     <= `REG_RESET;
            src_high_q    <= `REG_RESET;
            dst_low_q     <= `REG_RESET;
            dst_high_q    <= `REG_RESET;
            index_q       <= `REG_RESET;
        end else begin
            if (wr_match) match_count_q <= reg_wdata_i;
            if (wr_len)   length_q      <= reg_wdata_i;
            if (wr_srcl)  src_low_q     <= reg_wdata_i;
            if (wr_srch)  src_high_q    <= reg_wdata_i;
            if (wr_dstl)  dst_low_q     <= reg_wdata_i;
            if (wr_dsth)  dst_high_q    <= reg_wdata_i;
            // a software write to control wins over the hardware clear
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata_i & `CTRL_WRITE_MASK;
            end else if (state_q == S_DONE && last_item && !(circular && triggered)) begin
                ctrl_q[`CTRL_RUN_BIT] <= 1'b0;
            end
            // index counts stored items and wraps to zero at the end
            if (sw_stop) begin
                index_q <= `REG_RESET;
            end else if (state_q == S_DONE) begin
                index_q <= last_item ? `REG_RESET : index_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q     <= S_IDLE;
            hold_q      <= 1'b0;
            data_q      <= 32'h0000_0000;
            bus_req_o   <= 1'b0;
            bus_lock_o  <= 1'b0;
            mem_addr_o  <= 32'h0000_0000;
            mem_size_o  <= `WIDTH_BYTE;
            mem_rd_o    <= 1'b0;
            mem_wr_o    <= 1'b0;
            mem_wdata_o <= 32'h0000_0000;
            busy_o      <= 1'b0;
            irq_o       <= 1'b0;
        end else begin
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            irq_o    <= 1'b0;
            if (sw_stop) begin
                // channel off: drop everything, clocks would be gated here
                state_q    <= S_IDLE;
                hold_q     <= 1'b0;
                bus_req_o  <= 1'b0;
                bus_lock_o <= 1'b0;
                busy_o     <= 1'b0;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        if (run && (!triggered || periph_req_i)) begin
                            state_q   <= S_REQ;
                            bus_req_o <= 1'b1;
                            busy_o    <= 1'b1;
                        end else begin
                            busy_o    <= 1'b0;
                        end
                    end
                    S_REQ: begin
                        if (won) begin
                            hold_q     <= keep_bus;
                            bus_lock_o <= keep_bus;
                            mem_size_o <= width;
                            if (fill && index_q != 16'h0000) begin
                                // value already fetched: store it straight away
                                state_q     <= S_WRITE;
                                mem_addr_o  <= dst_addr;
                                mem_wdata_o <= data_q;
                                mem_wr_o    <= 1'b1;
                            end else begin
                                state_q    <= S_READ;
                                mem_addr_o <= src_addr;
                                mem_rd_o   <= 1'b1;
                            end
                        end
                    end
                    S_READ: begin
                        // read data stand beside the strobe and are taken at the edge that ends it
                        state_q     <= S_WRITE;
                        data_q      <= mem_rdata_i;
                        mem_addr_o  <= dst_addr;
                        mem_wdata_o <= mem_rdata_i;
                        mem_wr_o    <= 1'b1;
                    end
                    S_WRITE: begin
                        state_q <= S_DONE;
                    end
                    S_DONE: begin
                        // compare before the index moves on
                        irq_o <= irq_en && match_count_q == index_q;
                        if (last_item) begin
                            hold_q     <= 1'b0;
                            bus_lock_o <= 1'b0;
                            bus_req_o  <= 1'b0;
                            // circular triggered channels keep run and wait for the next request in idle
                            state_q    <= S_IDLE;
                        end else if (triggered) begin
                            hold_q     <= 1'b0;
                            bus_lock_o <= 1'b0;
                            bus_req_o  <= 1'b0;
                            state_q    <= S_IDLE;
                        end else if (yield && !fill) begin
                            // leave one free bus cycle for the processor or cache
                            bus_req_o <= 1'b0;
                            state_q   <= S_GAP;
                        end else begin
                            state_q <= S_REQ;
                        end
                    end
                    S_GAP: begin
                        bus_req_o <= 1'b1;
                        state_q   <= S_REQ;
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // register read port, data one cycle after the strobe
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                `OFS_IRQ_MATCH_COUNT:   reg_rdata_o <= match_count_q;
                `OFS_TRANSFER_LENGTH:   reg_rdata_o <= length_q;
                `OFS_CHANNEL_CONTROL:   reg_rdata_o <= ctrl_q;
                `OFS_ITEM_INDEX:        reg_rdata_o <= index_q;
                `OFS_SOURCE_START_LOW:  reg_rdata_o <= src_low_q;
                `OFS_SOURCE_START_HIGH: reg_rdata_o <= src_high_q;
                `OFS_DEST_START_LOW:    reg_rdata_o <= dst_low_q;
                `OFS_DEST_START_HIGH:   reg_rdata_o <= dst_high_q;
                default:                reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

endmodule

`default_nettype wire

// file: hw/dma_channel_defs.vh
// constants for the dma channel: register offsets, control fields, codes
`ifndef DMA_CHANNEL_DEFS_VH
`define DMA_CHANNEL_DEFS_VH

// ----------------------------------------
// register offsets (printed byte addresses)
// ----------------------------------------
`define OFS_IRQ_MATCH_COUNT   32'h5000_3568
`define OFS_TRANSFER_LENGTH   32'h5000_356a
`define OFS_CHANNEL_CONTROL   32'h5000_356c
`define OFS_ITEM_INDEX        32'h5000_356e
`define OFS_SOURCE_START_LOW  32'h5000_3570
`define OFS_SOURCE_START_HIGH 32'h5000_3572
`define OFS_DEST_START_LOW    32'h5000_3574
`define OFS_DEST_START_HIGH   32'h5000_3576

// ----------------------------------------
// channel_control fields
// ----------------------------------------
`define CTRL_RUN_BIT      0
`define CTRL_WIDTH_LSB    1
`define CTRL_WIDTH_MSB    2
`define CTRL_IRQ_EN_BIT   3
`define CTRL_TRIG_BIT     4
`define CTRL_DST_INC_BIT  5
`define CTRL_SRC_INC_BIT  6
`define CTRL_CIRC_BIT     7
`define CTRL_PRIO_LSB     8
`define CTRL_PRIO_MSB     10
`define CTRL_YIELD_BIT    11
`define CTRL_FILL_BIT     12
`define CTRL_WRITE_MASK   16'h1fff

// ----------------------------------------
// transfer width codes and reset values
// ----------------------------------------
`define WIDTH_BYTE        2'h0
`define WIDTH_HALF        2'h1
`define WIDTH_WORD        2'h2
`define REG_RESET         16'h0000

`endif

// file: hw/channel_priority_arbiter.v
// fixed priority arbiter over all dma channels
`timescale 1ns/1ps
`default_nettype none

module channel_priority_arbiter #(
    parameter NUM_CH = 8
) (
    input  wire [NUM_CH-1:0]   req_i,
    input  wire [3*NUM_CH-1:0] prio_i,
    output reg  [NUM_CH-1:0]   gnt_o
);

    // ----------------------------------------
    // pick the highest level; scanning downward with >= lets the lowest
    // channel number win a tie
    // ----------------------------------------
    integer  i;
    integer  win;
    reg [2:0] best;
    always @* begin
        gnt_o = {NUM_CH{1'b0}};
        best  = 3'h0;
        win   = -1;
        for (i = NUM_CH - 1; i >= 0; i = i - 1) begin
            if (req_i[i] && (win < 0 || prio_i[3*i +: 3] >= best)) begin
                best = prio_i[3*i +: 3];
                win  = i;
            end
        end
        if (win >= 0) begin
            gnt_o[win] = 1'b1;
        end
    end

endmodule

`default_nettype wire

// file: tb/mem_model.sv
// memory model on the far side of the channel's system bus
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        rd_i,
    input  wire logic [31:0] addr_i,
    output logic      [31:0] rdata_o
);
    logic [31:0] junk_q;
    // ------------------------------
    // read answer
    // ------------------------------
    // data beside the strobe, taken at the edge that ends it; else a pattern
    // that moves every cycle so a late sample never matches by luck
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            junk_q <= 32'hdead_0001;
        end else begin
            junk_q <= {junk_q[30:0], ~junk_q[31]};
        end
    end
    assign rdata_o = rd_i ? {~addr_i[15:0], addr_i[15:0]} : junk_q;
endmodule
`default_nettype wire

// file: tb/dma_channel_control_sva.sv
// port assertions for the dma channel
`timescale 1ns/1ps
`default_nettype none
`include "dma_channel_defs.vh"
module dma_channel_control_sva (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_we_i,
    input wire logic        reg_re_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        bus_req_o,
    input wire logic        bus_lock_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [1:0]  mem_size_o,
    input wire logic        mem_rd_o,
    input wire logic        mem_wr_o,
    input wire logic        busy_o,
    input wire logic        irq_o
);
    logic [15:0] ctrl_q, ctrl_p_q, src_lo_q, src_hi_q;
    logic        stop_q;
    wire  logic  ctrl_wr = reg_we_i && reg_addr_i == `OFS_CHANNEL_CONTROL;
    // ------------------------------
    // shadow of software writes
    // ------------------------------
    // delayed copy, so an abort racing a pulse is not misjudged
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q   <= 16'h0000;
            ctrl_p_q <= 16'h0000;
            src_lo_q <= 16'h0000;
            src_hi_q <= 16'h0000;
            stop_q   <= 1'b0;
        end else begin
            if (ctrl_wr) ctrl_q <= reg_wdata_i;
            if (reg_we_i && reg_addr_i == `OFS_SOURCE_START_LOW) src_lo_q <= reg_wdata_i;
            if (reg_we_i && reg_addr_i == `OFS_SOURCE_START_HIGH) src_hi_q <= reg_wdata_i;
            ctrl_p_q <= ctrl_q;
            stop_q   <= ctrl_wr && !reg_wdata_i[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------
    // properties
    // ------------------------------
    sequence start_s;
        ctrl_wr && reg_wdata_i[0] && !reg_wdata_i[4] && !busy_o;
    endsequence
    sequence first_rd_s;
        $rose(bus_lock_o) && mem_rd_o && !ctrl_q[4] && !ctrl_q[11];
    endsequence
    start_req_a: assert property (start_s |-> ##[1:3] bus_req_o)
        else $error("no bus request after start");
    first_src_a: assert property (first_rd_s |-> mem_addr_o == {src_hi_q, src_lo_q})
        else $error("first fetch not at source start");
    rd_then_wr_a: assert property (mem_rd_o |-> ##[1:2] (mem_wr_o || stop_q || ctrl_wr))
        else $error("fetch not followed by store");
    irq_pulse_a: assert property (irq_o |=> !irq_o)
        else $error("interrupt longer than one cycle");
    irq_enable_a: assert property (irq_o |-> ctrl_p_q[3])
        else $error("interrupt while disabled");
    size_width_a: assert property (mem_rd_o |-> mem_size_o == ctrl_p_q[2:1])
        else $error("item size differs from width field");
    rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside answer cycle");
    strobe_busy_a: assert property ((mem_rd_o || mem_wr_o) |-> busy_o && bus_req_o)
        else $error("bus strobe while idle");
    lock_busy_a: assert property (bus_lock_o |-> busy_o)
        else $error("bus held while idle");
    fill_lock_a: assert property (mem_wr_o && ctrl_p_q[12] |-> bus_lock_o)
        else $error("fill store without bus hold");
    // yielding copy frees the bus two cycles after each store
    yield_gap_a: assert property (mem_wr_o && ctrl_p_q[11] && !ctrl_p_q[4] && !ctrl_p_q[12] |-> ##2 !bus_req_o)
        else $error("no free bus cycle after store");
endmodule
bind dma_channel_control dma_channel_control_sva u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .bus_req_o(bus_req_o),
    .bus_lock_o(bus_lock_o), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .busy_o(busy_o), .irq_o(irq_o)
);
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench: one dma channel, memory model, competing channels
`timescale 1ns/1ps
`default_nettype none
`include "dma_channel_defs.vh"
module testbench;
    logic        clk_i, rst_n_i, reg_we_i, reg_re_i, periph_req_i;
    logic        bus_req_o, bus_lock_o, mem_rd_o, mem_wr_o, busy_o, irq_o;
    logic [31:0] reg_addr_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic [15:0] reg_wdata_i, reg_rdata_o;
    logic [1:0]  mem_size_o;
    logic [7:0]  other_req_i;
    logic [23:0] other_prio_i;
    logic [31:0] wa[$], wd[$];
    int          n_errors, compares, nrd, nirq, cyc;
    logic [31:0] ofs[8] = '{`OFS_IRQ_MATCH_COUNT, `OFS_TRANSFER_LENGTH, `OFS_CHANNEL_CONTROL,
        `OFS_ITEM_INDEX, `OFS_SOURCE_START_LOW, `OFS_SOURCE_START_HIGH, `OFS_DEST_START_LOW,
        `OFS_DEST_START_HIGH};
    // channel 2, so equal-priority channels on both sides of it exist
    dma_channel_control #(.NUM_CH(8), .CH_ID(2)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .other_req_i(other_req_i), .other_prio_i(other_prio_i), .periph_req_i(periph_req_i),
        .bus_req_o(bus_req_o), .bus_lock_o(bus_lock_o), .mem_addr_o(mem_addr_o),
        .mem_size_o(mem_size_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .irq_o(irq_o));
    mem_model mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
        .rdata_o(mem_rdata_i));
    // ------------------------------
    // clock, monitor and hang guard
    // ------------------------------
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (mem_wr_o === 1'b1) begin
            wa.push_back(mem_addr_o);
            wd.push_back(mem_wdata_o);
        end
        if (mem_rd_o === 1'b1) nrd++;
        if (irq_o === 1'b1) nirq++;
        if (cyc == 60000) begin
            n_errors++;
            conclude();
        end
    end
    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_we_i    <= 1'b1;
        @(posedge clk_i);
        reg_we_i    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic chk_rd(input string what, input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i   <= 1'b1;
        @(posedge clk_i);
        reg_re_i   <= 1'b0;
        #1;
        check(what, {16'h0000, reg_rdata_o}, exp);
    endtask
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        logic [15:0] v, ctrl, match, len;
        logic [31:0] src, dst, e, m;
        logic [7:0]  om;
        logic [23:0] op;
        logic        fill, trig, circ, sinc, dinc, irqen, yld, blk;
        logic [1:0]  w;
        logic [2:0]  prio;
        int          sz, n, i;
        rst_n_i = 1'b0;
        reg_we_i = 1'b0;
        reg_re_i = 1'b0;
        periph_req_i = 1'b0;
        reg_addr_i = 32'h0000_0000;
        reg_wdata_i = 16'h0000;
        other_req_i = 8'h00;
        other_prio_i = 24'h00_0000;
        v = 16'($urandom(75571));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 8; i++) chk_rd("reset value", ofs[i], 32'h0000_0000);
        for (i = 0; i < 8; i++) begin
            v = 16'($urandom);
            if (i == 2) v[0] = 1'b0;
            reg_wr(ofs[i], v);
            chk_rd("read back", ofs[i], (i == 3) ? 16'h0000 : (i == 2) ? v & 16'h1fff : v);
        end
        chk_rd("unmapped read", 32'h5000_3578, 32'h0000_0000);
        reg_wr(`OFS_CHANNEL_CONTROL, 16'h0000);
        $display("register test done");
        for (int t = 0; t < 16; t++) begin
            w = 2'($urandom_range(2));
            len = 16'($urandom_range(4));
            fill = ($urandom_range(3) == 0);
            trig = !fill && 1'($urandom);
            circ = trig && 1'($urandom);
            sinc = 1'($urandom);
            dinc = fill | 1'($urandom);
            irqen = 1'($urandom);
            yld = 1'($urandom);
            prio = 3'($urandom);
            match = 16'($urandom_range(5));
            src = $urandom;
            dst = $urandom;
            om = 8'($urandom) & 8'hfb;
            op = 24'($urandom);
            ctrl = {3'b000, fill, yld, prio, circ, sinc, dinc, trig, irqen, w, 1'b1};
            sz = 1 << w;
            n = circ ? 2 * (len + 1) : len + 1;
            blk = 1'b0;
            for (i = 0; i < 8; i++)
                if (om[i] && (op[3*i+:3] > prio || (op[3*i+:3] == prio && i < 2))) blk = 1'b1;
            wa.delete();
            wd.delete();
            nrd = 0;
            nirq = 0;
            other_req_i <= om;
            other_prio_i <= op;
            reg_wr(`OFS_IRQ_MATCH_COUNT, match);
            reg_wr(`OFS_TRANSFER_LENGTH, len);
            reg_wr(`OFS_SOURCE_START_LOW, src[15:0]);
            reg_wr(`OFS_SOURCE_START_HIGH, src[31:16]);
            reg_wr(`OFS_DEST_START_LOW, dst[15:0]);
            reg_wr(`OFS_DEST_START_HIGH, dst[31:16]);
            reg_wr(`OFS_CHANNEL_CONTROL, ctrl);
            repeat (40) @(posedge clk_i);
            if (trig || blk) check("fetches while held off", nrd, 0);
            else check("busy after free run", {31'h0, busy_o}, 0);
            other_req_i <= 8'h00;
            while (wa.size() < n) begin
                @(posedge clk_i);
                periph_req_i <= 1'($urandom);
            end
            if (circ) begin
                chk_rd("run kept in circular", `OFS_CHANNEL_CONTROL, ctrl);
                reg_wr(`OFS_CHANNEL_CONTROL, 16'h0000);
            end
            while (busy_o !== 1'b0) @(posedge clk_i);
            @(posedge clk_i);
            periph_req_i <= 1'b0;
            if (!circ) begin
                check("item count", wa.size(), n);
                check("fetches made", nrd, fill ? 1 : n);
                check("match interrupts", nirq, (irqen && match <= len) ? 1 : 0);
                chk_rd("run cleared at end", `OFS_CHANNEL_CONTROL, ctrl & 16'hfffe);
            end
            chk_rd("index back to zero", `OFS_ITEM_INDEX, 32'h0000_0000);
            m = (w == 2'd2) ? 32'hffff_ffff : (32'h1 << (8 * sz)) - 32'h1;
            for (i = 0; i < n && i < wa.size(); i++) begin
                e = fill ? src : src + (sinc ? (i % (len + 1)) * sz : 0);
                check("store address", wa[i], dst + (dinc ? (i % (len + 1)) * sz : 0));
                check("store data", wd[i] & m, {~e[15:0], e[15:0]} & m);
            end
            $display("transfer %0d done", t);
        end
        conclude();
    end
endmodule
`default_nettype wire
